// ==== rtl/bgrf_cfg.svh ====
`ifndef BGRF_CFG_SVH
`define BGRF_CFG_SVH
// ----------------------------------------
// Register offsets on the bus
// ----------------------------------------
`define BGRF_PSW_OFS 12'h000
`define BGRF_LOC_OFS 12'h004
`define BGRF_EXT_OFS 12'h010
`define BGRF_RAM_OFS 12'h200
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define BGRF_BANK_LSB 12
`define BGRF_SWAP_BIT 5
`define BGRF_PSW_RST 16'h0000
`define BGRF_LOC_RST 1'b0
`define BGRF_EXT_RST 8'h00
// ----------------------------------------
// Data-memory window and fixed offsets
// ----------------------------------------
`define BGRF_WIN_LOW 24'h00FE80
`define BGRF_WIN_HIGH 24'h0FFE80
`define BGRF_CS_OFS 2'b01
`define BGRF_QUAD_LO 4'hC
`define BGRF_SWAP_AX 4'h4
`endif

// ==== rtl/bgrf_pkg.sv ====
`default_nettype none
package bgrf_pkg;
    typedef enum logic [1:0] {K_BYTE, K_PAIR, K_WIDE, K_QUAD} bgrf_kind_t;
    typedef enum logic [4:0] {
        R_X, R_A, R_C, R_B, R_E, R_D, R_L, R_H, R_AX, R_BC,
        R_VP, R_UP, R_DE, R_HL, R_BASE_PTR, R_USP, R_STR_A, R_STR_B, R_QUAD
    } bgrf_role_t;
    typedef struct packed {
        logic named;
        bgrf_role_t role;
        bgrf_kind_t kind;
        logic [3:0] num;
        logic acc;
    } bgrf_op_t;
    typedef struct packed {
        logic req;
        logic [2:0] bank;
        logic [19:0] pc;
    } bgrf_cs_t;
    typedef struct packed {
        logic [3:0] b3;
        logic [3:0] b2;
        logic [3:0] b1;
        logic [3:0] b0;
        logic [1:0] cnt;
        logic ext;
        logic [1:0] xi;
    } bgrf_loc_t;
endpackage
`default_nettype wire

// ==== rtl/bgrf_regfile.sv ====
// Overview of operation
// - Sixteen byte registers per bank, each read and written alone.
// - Adjacent byte pairs form eight 16-bit pair registers per bank.
// - Pairs 4 to 7 extend by an 8-bit register to 24-bit pointers.
// - Banked registers live in RAM; the four extension bytes sit outside.
// - Eight banks; bank changes by select instruction or context switch.
// - Reset selects bank 0.
// - Active bank lives in three status-word flags, visible when read.
// - The bank RAM is also plain data memory in a movable window.
// - Byte n at offset n; pair n at 2n and 2n+1, low byte lower.
// - Swap bit moves accumulator group to bytes 4-7 and pairs 2-3.
// - Bytes 12-15, pairs 4-7 ignore swap; bytes 8-11 have no role.
// - Context switch stores PC low 16 bits in pair 2 of new bank.
// - Context switch stores PC top 4 bits and status bits 15:12 and 7:0 in pair 3.
// - Pairs 0 and 6 together hold the 32-bit quad operand.
// - Bytes 3 and 2 serve as decrement-and-branch loop counters.
// - Byte 2 counts string ops; 24-bit registers 6 and 7 are pointers.
// - 24-bit register 5 is the user stack pointer.
// - 24-bit register 4 is base; pairs 6, 7 and bytes 1, 3 are offsets.
// - Status word restore on return brings the old bank back.
`include "bgrf_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module bgrf_regfile (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire bgrf_pkg::bgrf_op_t rd_op,
    output logic [31:0] rd_data,
    input wire logic wr_en,
    input wire bgrf_pkg::bgrf_op_t wr_op,
    input wire logic [31:0] wr_data,
    input wire logic dec_req,
    input wire logic dec_use_c,
    output logic dec_nonzero,
    input wire bgrf_pkg::bgrf_cs_t cs,
    input wire logic sel_req,
    input wire logic [2:0] sel_bank,
    input wire logic psw_we,
    input wire logic [15:0] psw_wdata,
    output logic [15:0] program_status_word,
    input wire logic dm_en,
    input wire logic dm_we,
    input wire logic [23:0] dm_addr,
    input wire logic [7:0] dm_wdata,
    output logic dm_hit,
    output logic [7:0] dm_rdata
);
    import bgrf_pkg::*;

    // ----------------------------------------
    // Operand decoding
    // ----------------------------------------
    function automatic bgrf_op_t role_op(input bgrf_role_t r);
        bgrf_op_t o;
        o = '0;
        o.acc = 1'b0;
        unique case (r)
            R_X: begin
                o.kind = K_BYTE; o.num = 4'h0; o.acc = 1'b1;
            end
            R_A: begin
                o.kind = K_BYTE; o.num = 4'h1; o.acc = 1'b1;
            end
            R_C: begin
                o.kind = K_BYTE; o.num = 4'h2; o.acc = 1'b1;
            end
            R_B: begin
                o.kind = K_BYTE; o.num = 4'h3; o.acc = 1'b1;
            end
            R_E: begin
                o.kind = K_BYTE; o.num = 4'hC;
            end
            R_D: begin
                o.kind = K_BYTE; o.num = 4'hD;
            end
            R_L: begin
                o.kind = K_BYTE; o.num = 4'hE;
            end
            R_H: begin
                o.kind = K_BYTE; o.num = 4'hF;
            end
            R_AX: begin
                o.kind = K_PAIR; o.num = 4'h0; o.acc = 1'b1;
            end
            R_BC: begin
                o.kind = K_PAIR; o.num = 4'h1; o.acc = 1'b1;
            end
            R_VP: begin
                o.kind = K_PAIR; o.num = 4'h4;
            end
            R_UP: begin
                o.kind = K_PAIR; o.num = 4'h5;
            end
            R_DE: begin
                o.kind = K_PAIR; o.num = 4'h6;
            end
            R_HL: begin
                o.kind = K_PAIR; o.num = 4'h7;
            end
            R_BASE_PTR: begin
                o.kind = K_WIDE; o.num = 4'h4;
            end
            R_USP: begin
                o.kind = K_WIDE; o.num = 4'h5;
            end
            R_STR_A: begin
                o.kind = K_WIDE; o.num = 4'h6;
            end
            R_STR_B: begin
                o.kind = K_WIDE; o.num = 4'h7;
            end
            // Role codes past the list fold onto the quad operand
            default: begin
                o.kind = K_QUAD; o.num = 4'h0; o.acc = 1'b1;
            end
        endcase
        return o;
    endfunction

    function automatic bgrf_loc_t resolve(input bgrf_op_t op, input logic swap);
        bgrf_op_t o;
        logic [3:0] n;
        bgrf_loc_t l;
        o = op.named ? role_op(op.role) : op;
        n = o.num;
        l = '0;
        unique case (o.kind)
            // Accumulator bytes move up by four
            K_BYTE: begin
                if (swap && o.acc && n < 4'h4) begin
                    n = n + 4'h4;
                end
                l.b0 = n;
            end
            // Pair n at 2n and 2n+1
            K_PAIR: begin
                if (swap && o.acc && n < 4'h2) begin
                    n = n + 4'h2;
                end
                l.b0 = {n[2:0], 1'b0};
                l.b1 = {n[2:0], 1'b1};
                l.cnt = 2'd1;
            end
            K_WIDE: begin
                l.b0 = {1'b1, n[1:0], 1'b0};
                l.b1 = {1'b1, n[1:0], 1'b1};
                l.cnt = 2'd2;
                l.ext = 1'b1;
                l.xi = n[1:0];
            end
            // Quad is pair 0 over pair 6
            K_QUAD: begin
                l.b0 = `BGRF_QUAD_LO;
                l.b1 = `BGRF_QUAD_LO | 4'h1;
                l.b2 = (swap && o.acc) ? `BGRF_SWAP_AX : 4'h0;
                l.b3 = l.b2 | 4'h1;
                l.cnt = 2'd3;
            end
        endcase
        return l;
    endfunction

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    // Banked bytes in RAM, extensions apart
    logic [7:0] ram [128];
    logic [7:0] ext [4];
    logic loc_high;

    wire [2:0] bank = program_status_word[`BGRF_BANK_LSB +: 3];
    wire swap = program_status_word[`BGRF_SWAP_BIT];
    // Bank 0 at the top of the region
    wire [2:0] bank_row = ~bank;
    wire [2:0] cs_row = ~cs.bank;

    // ----------------------------------------
    // Core read port
    // ----------------------------------------
    wire bgrf_loc_t rl = resolve(rd_op, swap);
    wire [7:0] r0 = ram[{bank_row, rl.b0}];
    wire [7:0] r1 = ram[{bank_row, rl.b1}];
    wire [7:0] r2 = rl.ext ? ext[rl.xi] : ram[{bank_row, rl.b2}];
    wire [7:0] r3 = ram[{bank_row, rl.b3}];
    wire [31:0] next_rd_data = (rl.cnt == 2'd0) ? {24'h000000, r0} :
                               (rl.cnt == 2'd1) ? {16'h0000, r1, r0} :
                               (rl.cnt == 2'd2) ? {8'h00, r2, r1, r0} :
                               {r3, r2, r1, r0};

    // ----------------------------------------
    // Core write port and loop counter
    // ----------------------------------------
    // Loop counter is byte 2 or byte 3
    wire bgrf_op_t dec_op = '{named: 1'b0, role: R_X, kind: K_BYTE,
                               num: dec_use_c ? 4'h2 : 4'h3, acc: 1'b1};
    wire bgrf_loc_t dl = resolve(dec_op, swap);
    wire [7:0] dec_old = ram[{bank_row, dl.b0}];
    wire [7:0] dec_new = dec_old - 8'h01;
    // Decrement takes the write port; a plain write in that cycle is lost
    wire wr_go = dec_req | wr_en;
    wire bgrf_loc_t wl = dec_req ? dl : resolve(wr_op, swap);
    wire [31:0] wd = dec_req ? {24'h000000, dec_new} : wr_data;

    // ----------------------------------------
    // Context-switch save word
    // ----------------------------------------
    // Low PC into pair 2
    // High PC and status bits 15:12 and 7:0 into pair 3
    wire [31:0] cs_word = {program_status_word[15:12], cs.pc[19:16], program_status_word[7:0], cs.pc[15:0]};

    // ----------------------------------------
    // Data-memory window
    // ----------------------------------------
    // Window follows the location setting
    wire [23:0] win_base = loc_high ? `BGRF_WIN_HIGH : `BGRF_WIN_LOW;
    wire dm_in = dm_addr[23:7] == win_base[23:7];
    wire dm_wr = dm_en && dm_we && dm_in;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire bus_setup = psel && !penable;
    wire bus_acc = psel && penable && pready;
    wire hit_psw = paddr == `BGRF_PSW_OFS;
    wire hit_loc = paddr == `BGRF_LOC_OFS;
    wire hit_ext = paddr[11:4] == `BGRF_EXT_OFS >> 4 && paddr[1:0] == 2'b00;
    wire hit_ram = paddr[11:9] == `BGRF_RAM_OFS >> 9 && paddr[1:0] == 2'b00;
    wire mapped = hit_psw || hit_loc || hit_ext || hit_ram;
    wire bus_wr = bus_acc && pwrite && !pslverr;
    wire [6:0] bus_idx = paddr[8:2];
    wire [31:0] bus_rd = hit_psw ? {16'h0000, program_status_word} :
                         hit_loc ? {31'h00000000, loc_high} :
                         hit_ext ? {24'h000000, ext[paddr[3:2]]} :
                         hit_ram ? {24'h000000, ram[bus_idx]} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= bus_setup;
            if (bus_setup) begin
                prdata <= bus_rd;
                pslverr <= !mapped;
            end
        end
    end

    // ----------------------------------------
    // Status word
    // ----------------------------------------
    logic [15:0] next_psw;
    always_comb begin
        next_psw = program_status_word;
        if (bus_wr && hit_psw) begin
            if (pstrb[0]) begin
                next_psw[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
                next_psw[15:8] = pwdata[15:8];
            end
        end
        if (sel_req) begin
            next_psw[`BGRF_BANK_LSB +: 3] = sel_bank;
        end
        // Restored word brings its bank back
        if (psw_we) begin
            next_psw = psw_wdata;
        end
        if (cs.req) begin
            next_psw[`BGRF_BANK_LSB +: 3] = cs.bank;
        end
    end

    // Bank flags live in the status word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_status_word <= `BGRF_PSW_RST;
            loc_high <= `BGRF_LOC_RST;
        end else begin
            program_status_word <= next_psw;
            if (bus_wr && hit_loc && pstrb[0]) begin
                loc_high <= pwdata[0];
            end
        end
    end

    // ----------------------------------------
    // Registered answers to the core
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= 32'h00000000;
            dec_nonzero <= 1'b0;
            dm_hit <= 1'b0;
            dm_rdata <= 8'h00;
        end else begin
            rd_data <= next_rd_data;
            if (dec_req) begin
                dec_nonzero <= dec_new != 8'h00;
            end
            dm_hit <= dm_en && dm_in;
            dm_rdata <= dm_in ? ram[dm_addr[6:0]] : 8'h00;
        end
    end

    // ----------------------------------------
    // Extension registers
    // ----------------------------------------
    for (genvar x = 0; x < 4; x++) begin : g_ext
        localparam logic [1:0] XI = 2'(x);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ext[x] <= `BGRF_EXT_RST;
            end else if (wr_go && wl.ext && wl.xi == XI) begin
                ext[x] <= wd[23:16];
            end else if (bus_wr && hit_ext && pstrb[0] && paddr[3:2] == XI) begin
                ext[x] <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // Bank RAM bytes
    // ----------------------------------------
    // Same-byte priority: context switch, core, data memory, bus
    for (genvar g = 0; g < 128; g++) begin : g_ram
        localparam logic [6:0] IDX = 7'(g);
        wire cs_hit = cs.req && IDX[6:4] == cs_row && IDX[3:2] == `BGRF_CS_OFS;
        wire own = wr_go && IDX[6:4] == bank_row;
        wire s0 = own && IDX[3:0] == wl.b0;
        wire s1 = own && wl.cnt != 2'd0 && IDX[3:0] == wl.b1;
        wire s2 = own && wl.cnt == 2'd3 && IDX[3:0] == wl.b2;
        wire s3 = own && wl.cnt == 2'd3 && IDX[3:0] == wl.b3;
        wire [7:0] cw = s3 ? wd[31:24] : s2 ? wd[23:16] : s1 ? wd[15:8] : wd[7:0];
        wire dm_hit_b = dm_wr && dm_addr[6:0] == IDX;
        wire bus_hit = bus_wr && hit_ram && pstrb[0] && bus_idx == IDX;
        always_ff @(posedge pclk) begin
            if (cs_hit) begin
                ram[g] <= cs_word[8 * IDX[1:0] +: 8];
            end else if (s0 || s1 || s2 || s3) begin
                ram[g] <= cw;
            end else if (dm_hit_b) begin
                ram[g] <= dm_wdata;
            end else if (bus_hit) begin
                ram[g] <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [7:0] ram_r5 = ram[{bank_row, 4'h5}];
    wire [7:0] ram_pc0 = ram[{bank_row, 4'h4}];
    wire [7:0] ram_pc1 = ram[{bank_row, 4'h5}];
    wire [7:0] ram_hi = ram[{bank_row, 4'h7}];
    wire [7:0] ram_lo = ram[{bank_row, 4'h6}];
    wire [7:0] top_pc = ram[7'h74];

    a_reset_bank_zero: assert property ($rose(presetn) |-> bank == 3'd0)
        else $error("bank not zero after reset");
    a_cs_bank_set: assert property (cs.req |=> bank == $past(cs.bank))
        else $error("context switch bank not taken");
    a_cs_pc_low: assert property (cs.req |=> {ram_pc1, ram_pc0} == $past(cs.pc[15:0]))
        else $error("pc low not saved");
    a_cs_psw_save: assert property (cs.req |=> ram_hi[3:0] == $past(cs.pc[19:16])
        && ram_lo == $past(program_status_word[7:0]))
        else $error("pc high or status not saved");
    a_bank0_layout: assert property (cs.req && cs.bank == 3'd0 |=> top_pc == $past(cs.pc[7:0]))
        else $error("bank 0 not at region top");
    a_swap_accum: assert property (!rd_op.named && rd_op.kind == K_BYTE && rd_op.acc
        && rd_op.num == 4'h1 && swap |=> rd_data[7:0] == $past(ram_r5))
        else $error("swapped accumulator misread");
    a_psw_restore: assert property (psw_we && !cs.req |=> program_status_word == $past(psw_wdata))
        else $error("status word not restored");
    a_sel_bank: assert property (sel_req && !psw_we && !cs.req |=> bank == $past(sel_bank))
        else $error("select instruction ignored");
    a_dec_flag: assert property (dec_req |=> dec_nonzero == ($past(dec_old) != 8'h01))
        else $error("loop counter flag wrong");
    a_dm_window: assert property (dm_en |=> dm_hit == $past(dm_in))
        else $error("window hit wrong");
    a_bus_ready: assert property (bus_setup |=> pready ##1 !pready)
        else $error("bus answer timing wrong");

    c_cs_switch: cover property (cs.req ##1 psw_we);
    c_dec_loop: cover property (dec_req [*3]);
    c_bus_write: cover property (bus_wr && hit_ram);
endmodule
`default_nettype wire

// ==== dv/bgrf_core_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module bgrf_core_model (
    input wire logic pclk,
    output var bgrf_pkg::bgrf_op_t rd_op,
    output var logic wr_en,
    output var bgrf_pkg::bgrf_op_t wr_op,
    output var logic [31:0] wr_data,
    output var logic dec_req,
    output var logic dec_use_c,
    output var bgrf_pkg::bgrf_cs_t cs,
    output var logic sel_req,
    output var logic [2:0] sel_bank,
    output var logic psw_we,
    output var logic [15:0] psw_wdata,
    output var logic dm_en,
    output var logic dm_we,
    output var logic [23:0] dm_addr,
    output var logic [7:0] dm_wdata
);
    import bgrf_pkg::*;
    // ----------------------------------------
    // Core requests one cycle wide; the read operand rd_op stays driven
    // ----------------------------------------
    initial begin
        rd_op = '0;
        wr_en = 1'b0;
        wr_op = '0;
        wr_data = 32'h0;
        dec_req = 1'b0;
        dec_use_c = 1'b0;
        cs = '0;
        sel_req = 1'b0;
        sel_bank = 3'h0;
        psw_we = 1'b0;
        psw_wdata = 16'h0;
        dm_en = 1'b0;
        dm_we = 1'b0;
        dm_addr = 24'h0;
        dm_wdata = 8'h0;
    end
    task automatic do_rd(input bgrf_op_t op);
        @(posedge pclk);
        rd_op <= op;
        @(posedge pclk);
    endtask
    task automatic do_wr(input bgrf_op_t op, input logic [31:0] d);
        @(posedge pclk);
        wr_en <= 1'b1;
        wr_op <= op;
        wr_data <= d;
        @(posedge pclk);
        wr_en <= 1'b0;
    endtask
    task automatic do_dec(input logic c);
        @(posedge pclk);
        dec_req <= 1'b1;
        dec_use_c <= c;
        @(posedge pclk);
        dec_req <= 1'b0;
    endtask
    // Context switch carries the target bank and the full program counter
    task automatic do_cs(input logic [2:0] b, input logic [19:0] pc);
        @(posedge pclk);
        cs <= '{req: 1'b1, bank: b, pc: pc};
        @(posedge pclk);
        cs.req <= 1'b0;
    endtask
    task automatic do_sel(input logic [2:0] b);
        @(posedge pclk);
        sel_req <= 1'b1;
        sel_bank <= b;
        @(posedge pclk);
        sel_req <= 1'b0;
    endtask
    task automatic do_psw(input logic [15:0] v);
        @(posedge pclk);
        psw_we <= 1'b1;
        psw_wdata <= v;
        @(posedge pclk);
        psw_we <= 1'b0;
    endtask
    task automatic do_dm(input logic we, input logic [23:0] a, input logic [7:0] d);
        @(posedge pclk);
        dm_en <= 1'b1;
        dm_we <= we;
        dm_addr <= a;
        dm_wdata <= d;
        @(posedge pclk);
        dm_en <= 1'b0;
        dm_we <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import bgrf_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_data, r;
    logic [3:0] pstrb;
    logic [15:0] program_status_word, exp_psw, old;
    logic [2:0] b, nb;
    logic [19:0] pc;
    logic [7:0] dm_rdata;
    logic [7:0] mem [0:7][0:15];
    logic [7:0] ext [0:3];
    logic dm_hit, dec_nonzero;
    int mismatches, samples_checked, seed_v;
    bgrf_op_t rd_op, wr_op, aop;
    bgrf_cs_t cs;
    wire logic wr_en, dec_req, dec_use_c, sel_req, psw_we, dm_en, dm_we;
    wire logic [31:0] wr_data;
    wire logic [2:0] sel_bank;
    wire logic [15:0] psw_wdata;
    wire logic [23:0] dm_addr;
    wire logic [7:0] dm_wdata;
    bgrf_regfile i_bgrf_regfile (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rd_op(rd_op), .rd_data(rd_data), .wr_en(wr_en),
        .wr_op(wr_op), .wr_data(wr_data), .dec_req(dec_req), .dec_use_c(dec_use_c),
        .dec_nonzero(dec_nonzero), .cs(cs), .sel_req(sel_req), .sel_bank(sel_bank),
        .psw_we(psw_we), .psw_wdata(psw_wdata), .program_status_word(program_status_word), .dm_en(dm_en), .dm_we(dm_we),
        .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_hit(dm_hit), .dm_rdata(dm_rdata));
    bgrf_core_model u_core (.pclk(pclk), .rd_op(rd_op), .wr_en(wr_en), .wr_op(wr_op),
        .wr_data(wr_data), .dec_req(dec_req), .dec_use_c(dec_use_c), .cs(cs), .sel_req(sel_req),
        .sel_bank(sel_bank), .psw_we(psw_we), .psw_wdata(psw_wdata), .dm_en(dm_en),
        .dm_we(dm_we), .dm_addr(dm_addr), .dm_wdata(dm_wdata));
    // ----------------------------------------
    // Helpers and expectations
    // ----------------------------------------
    always #2 pclk = ~pclk;
    function automatic bgrf_op_t op_of(input bgrf_kind_t k, input int n, input logic nm);
        op_of = '0;
        op_of.kind = k;
        op_of.num = 4'(n);
        op_of.named = nm;
        op_of.role = bgrf_role_t'(5'(n));
    endfunction
    // Bank 0 sits highest in the window, bank 7 lowest
    function automatic int ram_idx(input logic [2:0] bk, input int o);
        ram_idx = (7 - int'(bk)) * 16 + o;
    endfunction
    function automatic logic [15:0] pair_exp(input logic [2:0] bk, input int n);
        pair_exp = {mem[bk][2 * n + 1], mem[bk][2 * n]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        samples_checked++;
        if (got !== ex) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_core(input bgrf_op_t op);
        u_core.do_rd(op);
        #1;
        r = rd_data;
    endtask
    task automatic stop_test();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (8000) @(posedge pclk);
        mismatches++;
        stop_test();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed_v = $urandom(37569);
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, mismatches, samples_checked} = '0;
        pstrb = 4'hF;
        exp_psw = 16'h0000;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("psw_reset", 32'h0, {16'h0, program_status_word});
        apb(1'b0, 12'h000, 32'h0);
        chk("psw_apb", 32'h0, r);
        for (int p = 0; p < 3; p++) begin
            b = (p == 0) ? 3'h0 : (p == 1) ? 3'h7 : 3'($urandom);
            exp_psw[14:12] = b;
            u_core.do_sel(b);
            apb(1'b0, 12'h000, 32'h0);
            chk("psw_bank", {16'h0, exp_psw}, r);
            for (int o = 0; o < 16; o++) begin
                mem[b][o] = 8'($urandom);
                u_core.do_wr(op_of(K_BYTE, o, 1'b0), {24'h0, mem[b][o]});
            end
            for (int o = 0; o < 16; o++) begin
                rd_core(op_of(K_BYTE, o, 1'b0));
                chk("byte", {24'h0, mem[b][o]}, r);
                apb(1'b0, 12'(32'h200 + 4 * ram_idx(b, o)), 32'h0);
                chk("ram_apb", {24'h0, mem[b][o]}, r);
                u_core.do_dm(1'b0, 24'h00FE80 + 24'(ram_idx(b, o)), 8'h0);
                #1;
                chk("dm_low", {23'h0, 1'b1, mem[b][o]}, {23'h0, dm_hit, dm_rdata});
            end
            mem[b][9] = 8'($urandom);
            apb(1'b1, 12'(32'h200 + 4 * ram_idx(b, 9)), {24'h0, mem[b][9]});
            mem[b][10] = 8'($urandom);
            u_core.do_dm(1'b1, 24'h00FE80 + 24'(ram_idx(b, 10)), mem[b][10]);
            for (int n = 0; n < 8; n++) begin
                rd_core(op_of(K_PAIR, n, 1'b0));
                chk("pair", {16'h0, pair_exp(b, n)}, r);
            end
        end
        apb(1'b1, 12'h004, 32'h1);
        u_core.do_dm(1'b0, 24'h0FFE80 + 24'(ram_idx(b, 3)), 8'h0);
        #1;
        chk("dm_high", {23'h0, 1'b1, mem[b][3]}, {23'h0, dm_hit, dm_rdata});
        u_core.do_dm(1'b0, 24'h00FE80, 8'h0);
        #1;
        chk("dm_miss", 32'h0, {23'h0, dm_hit, dm_rdata});
        for (int k = 0; k < 4; k++) begin
            ext[k] = 8'($urandom);
            apb(1'b1, 12'(16 + 4 * k), {24'h0, ext[k]});
            rd_core(op_of(K_WIDE, k + 4, 1'b0));
            chk("wide", {8'h0, ext[k], pair_exp(b, k + 4)}, r);
            rd_core(op_of(K_WIDE, int'(R_BASE_PTR) + k, 1'b1));
            chk("pointer_role", {8'h0, ext[k], pair_exp(b, k + 4)}, r);
        end
        ext[2] = 8'($urandom);
        mem[b][12] = 8'($urandom);
        mem[b][13] = 8'($urandom);
        u_core.do_wr(op_of(K_WIDE, 6, 1'b0), {8'h0, ext[2], mem[b][13], mem[b][12]});
        rd_core(op_of(K_WIDE, 6, 1'b0));
        chk("wide_wr", {8'h0, ext[2], pair_exp(b, 6)}, r);
        for (int s = 0; s < 2; s++) begin
            exp_psw[5] = s[0];
            u_core.do_psw(exp_psw);
            for (int j = 0; j < 8; j++) begin
                rd_core(op_of(K_BYTE, j, 1'b1));
                chk("role_byte", {24'h0, mem[b][j < 4 ? j + 4 * s : j + 8]}, r);
            end
            aop = op_of(K_BYTE, 1, 1'b0);
            aop.acc = 1'b1;
            rd_core(aop);
            chk("acc_byte", {24'h0, mem[b][1 + 4 * s]}, r);
            rd_core(op_of(K_PAIR, int'(R_BC), 1'b1));
            chk("role_bc", {16'h0, pair_exp(b, 1 + 2 * s)}, r);
            rd_core(op_of(K_PAIR, int'(R_DE), 1'b1));
            chk("role_de", {16'h0, pair_exp(b, 6)}, r);
            rd_core(op_of(K_QUAD, int'(R_QUAD), 1'b1));
            chk("quad", {pair_exp(b, 2 * s), pair_exp(b, 6)}, r);
        end
        exp_psw[5] = 1'b0;
        u_core.do_psw(exp_psw);
        u_core.do_wr(op_of(K_BYTE, 2, 1'b0), 32'h1);
        mem[b][2] = 8'h01;
        for (int t = 0; t < 3; t++) begin
            u_core.do_dec(t < 2);
            if (t < 2) mem[b][2] = mem[b][2] - 8'h1;
            else mem[b][3] = mem[b][3] - 8'h1;
            #1;
            chk("dec_nz", {31'h0, mem[b][t < 2 ? 2 : 3] != 8'h0}, {31'h0, dec_nonzero});
            rd_core(op_of(K_BYTE, t < 2 ? 2 : 3, 1'b0));
            chk("dec_byte", {24'h0, mem[b][t < 2 ? 2 : 3]}, r);
        end
        nb = 3'($urandom);
        pc = 20'($urandom);
        old = exp_psw;
        u_core.do_cs(nb, pc);
        #1;
        chk("cs_bank", {29'h0, nb}, {29'h0, program_status_word[14:12]});
        rd_core(op_of(K_PAIR, 2, 1'b0));
        chk("cs_pc_low", {16'h0, pc[15:0]}, r);
        rd_core(op_of(K_PAIR, 3, 1'b0));
        chk("cs_pc_psw", {16'h0, old[15:12], pc[19:16], old[7:0]}, r);
        u_core.do_psw(old);
        #1;
        chk("psw_restore", {16'h0, old}, {16'h0, program_status_word});
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped", 32'h1, {r[30:0], e});
        stop_test();
    end
endmodule
`default_nettype wire
